// ===== design/sps_evt_if.sv
`timescale 1ns/10ps
// event carried from link domain to core domain by a toggle
interface sps_evt_if;
    logic toggle;
    logic pulse;
    modport src (output toggle, input pulse);
    modport sync (input toggle, output pulse);
endinterface

// ===== design/sps_pkg.sv
//==========================================================================
package sps_pkg;
    localparam int ADDR_W = 18;
    localparam int REG_ADDR_W = 24;
    localparam int LOCK_BIT = 7;
    localparam int TB_BIT = 5;
    localparam int BP_HI = 4;
    localparam int BP_LO = 2;
    localparam int WEL_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam int SUSP_BIT = 4;
    localparam int ABORT_BIT = 3;
    localparam logic [2:0] BP_ALL = 3'h7;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [REG_ADDR_W-1:0] SR1_NV_ADDR = 24'h000000;
    localparam logic [REG_ADDR_W-1:0] SR1_V_ADDR = 24'h070000;
    localparam logic [REG_ADDR_W-1:0] SR2_NV_ADDR = 24'h000001;
    localparam logic [REG_ADDR_W-1:0] SR2_V_ADDR = 24'h070001;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_SPECIAL_WRITE = 8'h42;
    localparam logic [7:0] OP_ANY_REG_WRITE = 8'h71;
    localparam logic [7:0] OP_SERIAL_WRITE = 8'hc2;
    localparam logic [REG_ADDR_W:0] CRC_MIN_SPAN = 25'h0000003;
endpackage

// ===== design/sps_status_protect.sv
`timescale 1ns/10ps
module sps_status_protect
#(
    parameter int ADDR_W = sps_pkg::ADDR_W,
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_STATUS1_READ = 8'h05,
    parameter logic [7:0] OP_STATUS2_READ = 8'h07,
    parameter logic [7:0] OP_ANY_REG_READ = 8'h65,
    parameter logic [7:0] OP_CRC_CALC = 8'h5b,
    parameter logic [7:0] OP_CRC_SUSPEND = 8'hb0,
    parameter logic [7:0] OP_CRC_RESUME = 8'h30,
    parameter logic [7:0] OP_RESET_ENABLE = 8'h66,
    parameter logic [7:0] OP_RESET = 8'h99
)
(
    // core clock and reset
    clock,
    rst_b,
    // link side, on the serial clock
    linkClock,
    cmdStrobe,
    cmdOpcode,
    cmdAddr,
    cmdEndAddr,
    cmdData,
    byteStrobe,
    byteAddr,
    // pins
    csB,
    wpPin,
    // crc engine
    crcDone,
    // status and grants
    protectStatus,
    crcStatus,
    readData,
    readValid,
    cmdAccept,
    regWriteAllow,
    memWriteOk,
    memWriteAddr,
    crcStart,
    crcSuspend,
    softReset
);
    localparam int RW = sps_pkg::REG_ADDR_W;

    input wire logic clock;
    input wire logic rst_b;
    input wire logic linkClock;
    input wire logic cmdStrobe;
    input wire logic [7:0] cmdOpcode;
    input wire logic [RW-1:0] cmdAddr;
    input wire logic [RW-1:0] cmdEndAddr;
    input wire logic [7:0] cmdData;
    input wire logic byteStrobe;
    input wire logic [ADDR_W-1:0] byteAddr;
    input wire logic csB;
    input wire logic wpPin;
    input wire logic crcDone;
    output logic [7:0] protectStatus;
    output logic [7:0] crcStatus;
    output logic [7:0] readData;
    output logic readValid;
    output logic cmdAccept;
    output logic regWriteAllow;
    output logic memWriteOk;
    output logic [ADDR_W-1:0] memWriteAddr;
    output logic crcStart;
    output logic crcSuspend;
    output logic softReset;

    //==================================================================
    // reset release and pin synchronisers
    logic rstMeta_q;
    logic rstB_q;
    logic csMeta_q;
    logic csSync_q;
    logic csPrev_q;
    logic wpMeta_q;
    logic wpSync_q;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_q <= 1'b0;
            rstB_q <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstB_q <= rstMeta_q;
        end
    end

    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
            wpMeta_q <= 1'b0;
            wpSync_q <= 1'b0;
        end
        else
        begin
            csMeta_q <= csB;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
            wpMeta_q <= wpPin;
            wpSync_q <= wpMeta_q;
        end
    end

    logic frameEnd;
    assign frameEnd = csSync_q & ~csPrev_q;

    //==================================================================
    // link domain capture, held stable until the next strobe
    logic [7:0] lnkOp_q;
    logic [RW-1:0] lnkAddr_q;
    logic [RW-1:0] lnkEnd_q;
    logic [7:0] lnkData_q;
    logic [ADDR_W-1:0] lnkByte_q;
    sps_evt_if cmdEvt ();
    sps_evt_if byteEvt ();

    always_ff @(posedge linkClock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            lnkOp_q <= 8'h00;
            lnkAddr_q <= '0;
            lnkEnd_q <= '0;
            lnkData_q <= 8'h00;
            cmdEvt.toggle <= 1'b0;
        end
        else if (cmdStrobe)
        begin
            lnkOp_q <= cmdOpcode;
            lnkAddr_q <= cmdAddr;
            lnkEnd_q <= cmdEndAddr;
            lnkData_q <= cmdData;
            cmdEvt.toggle <= ~cmdEvt.toggle;
        end
    end

    always_ff @(posedge linkClock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            lnkByte_q <= '0;
            byteEvt.toggle <= 1'b0;
        end
        else if (byteStrobe)
        begin
            lnkByte_q <= byteAddr;
            byteEvt.toggle <= ~byteEvt.toggle;
        end
    end

    sps_toggle_sync cmdSync (.clock(clock), .rstB(rstB_q), .evt(cmdEvt));
    sps_toggle_sync byteSync (.clock(clock), .rstB(rstB_q), .evt(byteEvt));

    //==================================================================
    // command decode and filtering
    logic lock_q;
    logic topBottom_q;
    logic [2:0] blockProt_q;
    logic [7:0] nvStatus_q;
    logic wel_q;
    logic pendClear_q;
    logic crcRun_q;
    logic crcSusp_q;
    logic crcAbort_q;
    logic rstArmed_q;
    logic busy;
    logic regLocked;
    logic isRead;
    logic allowBusy;
    logic accept;
    logic sr1Write;
    logic swReset;
    logic crcShort;
    logic byteProt;
    logic [7:0] sr1Now;
    logic [7:0] sr2Now;

    assign busy = crcRun_q & ~crcSusp_q;
    assign regLocked = lock_q & ~wpSync_q;
    assign isRead = (lnkOp_q == OP_STATUS1_READ) || (lnkOp_q == OP_STATUS2_READ)
        || (lnkOp_q == OP_ANY_REG_READ);
    assign allowBusy = isRead || (lnkOp_q == OP_CRC_SUSPEND)
        || (lnkOp_q == OP_RESET_ENABLE) || (lnkOp_q == OP_RESET);
    assign accept = cmdEvt.pulse & (~busy | allowBusy);
    assign sr1Write = accept & wel_q & ~regLocked
        & ((lnkOp_q == sps_pkg::OP_STATUS_WRITE)
        || ((lnkOp_q == sps_pkg::OP_ANY_REG_WRITE)
        && ((lnkAddr_q == sps_pkg::SR1_NV_ADDR) || (lnkAddr_q == sps_pkg::SR1_V_ADDR))));
    assign swReset = accept & rstArmed_q & (lnkOp_q == OP_RESET);
    assign crcShort = {1'b0, lnkEnd_q} < ({1'b0, lnkAddr_q} + sps_pkg::CRC_MIN_SPAN);

    // range of the array guarded by the block-protect code
    function automatic logic inRange(input logic [2:0] code, input logic tb,
                                     input logic [ADDR_W-1:0] addr);
        logic hit;
        logic [2:0] span;
        hit = (code != sps_pkg::BP_NONE);
        span = sps_pkg::BP_ALL - code;
        for (int i = 0; i < int'(sps_pkg::BP_ALL) - 1; i++)
        begin
            if ((i < int'(span)) && (addr[ADDR_W-1-i] == tb))
            begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    assign byteProt = inRange(blockProt_q, topBottom_q, lnkByte_q);
    assign sr1Now = {lock_q, 1'b0, topBottom_q, blockProt_q, wel_q, busy};
    assign sr2Now = {3'h0, crcSusp_q, crcAbort_q, 3'h0};

    //==================================================================
    // volatile and nonvolatile protection fields
    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            nvStatus_q <= sps_pkg::SR_RESET;
        end
        else if (sr1Write && (lnkAddr_q != sps_pkg::SR1_V_ADDR
                 || lnkOp_q == sps_pkg::OP_STATUS_WRITE))
        begin
            nvStatus_q <= lnkData_q;
        end
    end

    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            lock_q <= 1'b0;
            topBottom_q <= 1'b0;
            blockProt_q <= sps_pkg::BP_NONE;
        end
        else if (swReset)
        begin
            lock_q <= nvStatus_q[sps_pkg::LOCK_BIT];
            topBottom_q <= nvStatus_q[sps_pkg::TB_BIT];
            blockProt_q <= nvStatus_q[sps_pkg::BP_HI:sps_pkg::BP_LO];
        end
        else if (sr1Write)
        begin
            lock_q <= lnkData_q[sps_pkg::LOCK_BIT];
            topBottom_q <= lnkData_q[sps_pkg::TB_BIT];
            blockProt_q <= lnkData_q[sps_pkg::BP_HI:sps_pkg::BP_LO];
        end
    end

    //==================================================================
    // write enable latch
    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            wel_q <= 1'b0;
            pendClear_q <= 1'b0;
        end
        else if (swReset)
        begin
            wel_q <= 1'b0;
            pendClear_q <= 1'b0;
        end
        else
        begin
            if (accept && lnkOp_q == OP_WRITE_ENABLE)
            begin
                wel_q <= 1'b1;
            end
            else if (frameEnd && pendClear_q)
            begin
                wel_q <= 1'b0;
            end
            if (accept && (lnkOp_q == sps_pkg::OP_WRITE_DISABLE
                || lnkOp_q == sps_pkg::OP_STATUS_WRITE
                || lnkOp_q == sps_pkg::OP_SPECIAL_WRITE
                || lnkOp_q == sps_pkg::OP_ANY_REG_WRITE
                || lnkOp_q == sps_pkg::OP_SERIAL_WRITE))
            begin
                pendClear_q <= 1'b1;
            end
            else if (frameEnd)
            begin
                pendClear_q <= 1'b0;
            end
        end
    end

    //==================================================================
    // crc run, suspend and abort
    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            crcRun_q <= 1'b0;
            crcSusp_q <= 1'b0;
            crcAbort_q <= 1'b0;
            crcStart <= 1'b0;
        end
        else if (swReset)
        begin
            crcRun_q <= 1'b0;
            crcSusp_q <= 1'b0;
            crcAbort_q <= 1'b0;
            crcStart <= 1'b0;
        end
        else
        begin
            crcStart <= 1'b0;
            if (accept && lnkOp_q == OP_CRC_CALC)
            begin
                crcAbort_q <= crcShort;
                crcRun_q <= ~crcShort;
                crcStart <= ~crcShort;
            end
            else if (crcDone)
            begin
                crcRun_q <= 1'b0;
                crcSusp_q <= 1'b0;
            end
            if (accept && busy && lnkOp_q == OP_CRC_SUSPEND)
            begin
                crcSusp_q <= 1'b1;
            end
            else if (accept && crcSusp_q && lnkOp_q == OP_CRC_RESUME)
            begin
                crcSusp_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            rstArmed_q <= 1'b0;
            softReset <= 1'b0;
        end
        else
        begin
            softReset <= swReset;
            if (accept)
            begin
                rstArmed_q <= (lnkOp_q == OP_RESET_ENABLE);
            end
        end
    end

    //==================================================================
    // outputs: status images, reads and grants
    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            protectStatus <= sps_pkg::SR_RESET;
            crcStatus <= sps_pkg::SR_RESET;
            regWriteAllow <= 1'b0;
            cmdAccept <= 1'b0;
            crcSuspend <= 1'b0;
        end
        else
        begin
            crcSuspend <= crcSusp_q;
            protectStatus <= sr1Now;
            crcStatus <= sr2Now;
            regWriteAllow <= wel_q & ~regLocked & ~busy;
            cmdAccept <= accept;
        end
    end

    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            readData <= 8'h00;
            readValid <= 1'b0;
        end
        else
        begin
            readValid <= 1'b0;
            if (accept && lnkOp_q == OP_STATUS1_READ)
            begin
                readData <= sr1Now;
                readValid <= 1'b1;
            end
            else if (accept && lnkOp_q == OP_STATUS2_READ)
            begin
                readData <= sr2Now;
                readValid <= 1'b1;
            end
            else if (accept && lnkOp_q == OP_ANY_REG_READ)
            begin
                if (lnkAddr_q == sps_pkg::SR1_NV_ADDR || lnkAddr_q == sps_pkg::SR1_V_ADDR)
                begin
                    readData <= sr1Now;
                    readValid <= 1'b1;
                end
                else if (lnkAddr_q == sps_pkg::SR2_NV_ADDR
                         || lnkAddr_q == sps_pkg::SR2_V_ADDR)
                begin
                    readData <= sr2Now;
                    readValid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstB_q)
    begin
        if (!rstB_q)
        begin
            memWriteOk <= 1'b0;
            memWriteAddr <= '0;
        end
        else
        begin
            memWriteOk <= byteEvt.pulse & wel_q & ~busy & ~byteProt;
            memWriteAddr <= lnkByte_q;
        end
    end

    //==================================================================
    // checks
    a_lock_freezes: assert property (@(posedge clock) disable iff (!rstB_q)
        regLocked && !swReset |=> $stable({lock_q, topBottom_q, blockProt_q}))
        else $error("locked status fields changed");
    a_unlock_writes: assert property (@(posedge clock) disable iff (!rstB_q)
        accept && wel_q && !lock_q && lnkOp_q == sps_pkg::OP_STATUS_WRITE
        |=> blockProt_q == $past(lnkData_q[sps_pkg::BP_HI:sps_pkg::BP_LO]))
        else $error("unlocked status write lost");
    a_prot_drop: assert property (@(posedge clock) disable iff (!rstB_q)
        byteEvt.pulse && byteProt |=> !memWriteOk)
        else $error("protected byte granted");
    a_wel_gates: assert property (@(posedge clock) disable iff (!rstB_q)
        memWriteOk |-> $past(wel_q))
        else $error("write granted with latch clear");
    a_wel_cause: assert property (@(posedge clock) disable iff (!rstB_q)
        $rose(wel_q) |-> $past(accept && lnkOp_q == OP_WRITE_ENABLE))
        else $error("latch set without write enable");
    a_wel_clear: assert property (@(posedge clock) disable iff (!rstB_q)
        frameEnd && pendClear_q && !(accept && lnkOp_q == OP_WRITE_ENABLE) |=> !wel_q)
        else $error("latch not cleared at frame end");
    a_busy_cause: assert property (@(posedge clock) disable iff (!rstB_q)
        $rose(crcRun_q) |-> $past(accept && lnkOp_q == OP_CRC_CALC))
        else $error("busy set without crc start");
    a_busy_filter: assert property (@(posedge clock) disable iff (!rstB_q)
        busy && cmdEvt.pulse && lnkOp_q == OP_WRITE_ENABLE |=> !cmdAccept && $stable(wel_q))
        else $error("command taken while busy");
    a_sr2_image: assert property (@(posedge clock) disable iff (!rstB_q)
        ##1 crcStatus[sps_pkg::SUSP_BIT] == $past(crcSusp_q))
        else $error("suspend flag image wrong");
    a_abort_short: assert property (@(posedge clock) disable iff (!rstB_q)
        accept && lnkOp_q == OP_CRC_CALC && crcShort |=> ##1 crcStatus[sps_pkg::ABORT_BIT])
        else $error("abort flag not raised");
    a_sr2_reserved: assert property (@(posedge clock) disable iff (!rstB_q)
        (crcStatus & 8'he7) == 8'h00)
        else $error("reserved crc status bits set");
    c_wel_cycle: cover property (@(posedge clock) disable iff (!rstB_q)
        $rose(wel_q) ##[1:1000] $fell(wel_q));
    c_prot_drop: cover property (@(posedge clock) disable iff (!rstB_q)
        byteEvt.pulse && byteProt && wel_q);
    c_suspend: cover property (@(posedge clock) disable iff (!rstB_q)
        $rose(crcSusp_q));
endmodule

// ===== design/sps_toggle_sync.sv
`timescale 1ns/10ps
module sps_toggle_sync
(
    // core clock and reset
    input wire logic clock,
    input wire logic rstB,
    // event
    sps_evt_if.sync evt
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clock or negedge rstB)
    begin
        if (!rstB)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= evt.toggle;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign evt.pulse = sync_q ^ prev_q;
endmodule

// ===== testbench/sps_host_model.sv
`timescale 1ns/10ps
module sps_host_model
(
    // link clock and select
    output logic linkClock,
    output logic csB,
    // decoded command
    output logic cmdStrobe,
    output logic [7:0] cmdOpcode,
    output logic [23:0] cmdAddr,
    output logic [23:0] cmdEndAddr,
    output logic [7:0] cmdData,
    // array byte
    output logic byteStrobe,
    output logic [17:0] byteAddr
);
    initial
    begin
        linkClock = 1'b0;
        csB = 1'b1;
        cmdStrobe = 1'b0;
        byteStrobe = 1'b0;
        cmdOpcode = 8'h00;
        cmdAddr = 24'h000000;
        cmdEndAddr = 24'h000000;
        cmdData = 8'h00;
        byteAddr = 18'h00000;
    end

    //==========================================================
    // one frame, clock runs only while selected
    task automatic send(input logic isByte, input logic [7:0] op, input logic [23:0] a,
        input logic [23:0] ea, input logic [7:0] d);
        csB = 1'b0;
        #62.5 linkClock = 1'b1;
        #1;
        cmdOpcode = op;
        cmdAddr = a;
        cmdEndAddr = ea;
        cmdData = d;
        byteAddr = a[17:0];
        cmdStrobe = !isByte;
        byteStrobe = isByte;
        #61.5 linkClock = 1'b0;
        #62.5 linkClock = 1'b1;
        #1;
        cmdStrobe = 1'b0;
        byteStrobe = 1'b0;
        // released lines show the inverse
        cmdOpcode = ~cmdOpcode;
        cmdAddr = ~cmdAddr;
        cmdEndAddr = ~cmdEndAddr;
        cmdData = ~cmdData;
        byteAddr = ~byteAddr;
        #61.5 linkClock = 1'b0;
        #62.5 linkClock = 1'b1;
        #62.5 linkClock = 1'b0;
        #10 csB = 1'b1;
        #100;
    endtask
endmodule

// ===== testbench/sps_status_protect_test.sv
`timescale 1ns/10ps
module sps_status_protect_test;
    logic clock, rst_b, linkClock, csB, wpPin, crcDone, cmdStrobe, byteStrobe;
    logic [7:0] cmdOpcode, cmdData, protectStatus, crcStatus, readData, sr;
    logic [23:0] cmdAddr, cmdEndAddr;
    logic [17:0] byteAddr, memWriteAddr, lastOk, bnd;
    logic readValid, cmdAccept, regWriteAllow, memWriteOk, crcStart, softReset, crcSuspend;
    logic [7:0] lastRead;
    logic [7:0] ops [5] = '{8'h04, 8'h01, 8'h42, 8'h71, 8'hc2};
    int errorCnt = 0;
    int checked = 0;
    int accCnt, okCnt, startCnt, rstCnt;

    sps_status_protect u_sps_status_protect
    (
        .clock(clock), .rst_b(rst_b), .linkClock(linkClock), .cmdStrobe(cmdStrobe),
        .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdEndAddr(cmdEndAddr),
        .cmdData(cmdData), .byteStrobe(byteStrobe), .byteAddr(byteAddr), .csB(csB),
        .wpPin(wpPin), .crcDone(crcDone), .protectStatus(protectStatus),
        .crcStatus(crcStatus), .readData(readData), .readValid(readValid),
        .cmdAccept(cmdAccept), .regWriteAllow(regWriteAllow), .memWriteOk(memWriteOk),
        .memWriteAddr(memWriteAddr), .crcStart(crcStart), .crcSuspend(crcSuspend),
        .softReset(softReset)
    );

    sps_host_model u_sps_host_model
    (
        .linkClock(linkClock), .csB(csB), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
        .cmdAddr(cmdAddr), .cmdEndAddr(cmdEndAddr), .cmdData(cmdData),
        .byteStrobe(byteStrobe), .byteAddr(byteAddr)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    //==========================================================
    // pulse monitor
    always @(posedge clock)
    begin
        accCnt += int'(cmdAccept === 1'b1);
        okCnt += int'(memWriteOk === 1'b1);
        startCnt += int'(crcStart === 1'b1);
        rstCnt += int'(softReset === 1'b1);
        if (readValid === 1'b1)
            lastRead = readData;
        if (memWriteOk === 1'b1)
            lastOk = memWriteAddr;
    end

    //==========================================================
    // tasks
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a = 24'h0,
        input logic [7:0] d = 8'h00, input logic [23:0] ea = 24'h0);
        accCnt = 0;
        startCnt = 0;
        rstCnt = 0;
        lastRead = 8'h00;
        u_sps_host_model.send(1'b0, op, a, ea, d);
    endtask

    task automatic wbyte(input logic [17:0] a, input logic exp);
        okCnt = 0;
        u_sps_host_model.send(1'b1, 8'h02, {6'h00, a}, 24'h0, 8'h00);
        cmp("writeOk", {23'h0, exp}, okCnt[23:0]);
        if (exp)
            cmp("writeAddr", {6'h00, a}, {6'h00, lastOk});
    endtask

    function automatic logic [18:0] span(input logic [2:0] c);
        if (c == 3'h0)
            return 19'h00000;
        if (c == 3'h7)
            return 19'h40000;
        return 19'h01000 << (c - 3'h1);
    endfunction

    function automatic logic isProt(input logic tb, input logic [2:0] c, input logic [17:0] a);
        if (tb)
            return {1'b0, a} < span(c);
        return {1'b0, a} >= 19'h40000 - span(c);
    endfunction

    initial
    begin
        #200000;
        errorCnt++;
        finish_test();
    end

    //==========================================================
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        wpPin = 1'b0;
        crcDone = 1'b0;
        repeat (2) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge clock);
        cmp("status", 8'h00, protectStatus);
        cmp("crcStatus", 8'h00, crcStatus);
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 8; c++)
            begin
                sr = {2'b00, t[0], c[2:0], 2'b00};
                cmd(8'h06);
                cmd(8'h01, 24'h0, sr);
                cmp("status", sr, protectStatus);
                cmd(8'h06);
                cmp("status", sr | 8'h02, protectStatus);
                bnd = t[0] ? 18'(span(c[2:0])) : 18'(19'h40000 - span(c[2:0]));
                wbyte(18'h00000, !isProt(t[0], c[2:0], 18'h00000));
                wbyte(18'h3ffff, !isProt(t[0], c[2:0], 18'h3ffff));
                wbyte(bnd, !isProt(t[0], c[2:0], bnd));
                wbyte(bnd - 18'h1, !isProt(t[0], c[2:0], bnd - 18'h1));
                cmp("wel", 1, protectStatus[1]);
            end
        cmd(8'h06);
        cmd(8'h01, 24'h0, 8'h00);
        wbyte(18'h00010, 1'b0);
        cmd(8'h01, 24'h0, 8'h04);
        cmp("status", 8'h00, protectStatus);
        cmd(8'h06);
        cmd(8'h01, 24'h0, 8'h80);
        cmp("status", 8'h80, protectStatus);
        cmd(8'h06);
        cmp("regAllow", 0, regWriteAllow);
        cmd(8'h71, 24'h070000, 8'h00);
        cmp("lock", 6'h20, protectStatus[7:2]);
        @(posedge clock);
        #1 wpPin = 1'b1;
        repeat (4) @(posedge clock);
        cmd(8'h06);
        cmp("regAllow", 1, regWriteAllow);
        cmd(8'h01, 24'h0, 8'h00);
        cmp("status", 8'h00, protectStatus);
        cmd(8'h06);
        cmd(8'h71, 24'h070000, 8'h0c);
        cmp("status", 8'h0c, protectStatus);
        cmd(8'h65, 24'h000000);
        cmp("read", 8'h0c, lastRead);
        cmd(8'h06);
        cmd(8'h66);
        cmd(8'h99);
        cmp("softReset", 1, rstCnt);
        cmp("status", 8'h00, protectStatus);
        foreach (ops[i])
        begin
            cmd(8'h06);
            cmd(ops[i], 24'h000002, 8'h00);
            cmp("wel", 0, protectStatus[1]);
        end
        cmd(8'h5b, 24'h0, 8'h00, 24'h000100);
        cmp("crcStart", 1, startCnt);
        cmp("status", 8'h01, protectStatus);
        cmd(8'h06);
        cmp("accept", 0, accCnt);
        cmp("status", 8'h01, protectStatus);
        cmd(8'h05);
        cmp("accept", 1, accCnt);
        cmp("read", 8'h01, lastRead);
        cmd(8'hb0);
        cmp("crcStatus", 8'h10, crcStatus);
        cmp("crcSuspend", 1, crcSuspend);
        cmd(8'h30);
        cmp("crcStatus", 8'h00, crcStatus);
        cmp("crcSuspend", 0, crcSuspend);
        cmp("status", 8'h01, protectStatus);
        @(posedge clock);
        #1 crcDone = 1'b1;
        @(posedge clock);
        #1 crcDone = 1'b0;
        repeat (4) @(posedge clock);
        cmp("status", 8'h00, protectStatus);
        cmd(8'h5b, 24'h000010, 8'h00, 24'h000012);
        cmp("crcStart", 0, startCnt);
        cmp("crcStatus", 8'h08, crcStatus);
        cmd(8'h65, 24'h000001);
        cmp("read", 8'h08, lastRead);
        cmd(8'h65, 24'h070001);
        cmp("read", 8'h08, lastRead);
        cmd(8'h07);
        cmp("read", 8'h08, lastRead);
        cmd(8'h06);
        cmd(8'h71, 24'h070001, 8'hff);
        cmp("crcStatus", 8'h08, crcStatus);
        cmd(8'h5b, 24'h000010, 8'h00, 24'h000013);
        cmp("crcStart", 1, startCnt);
        cmp("crcStatus", 8'h00, crcStatus);
        cmd(8'hb0);
        cmp("crcStatus", 8'h10, crcStatus);
        cmd(8'h66);
        cmd(8'h99);
        cmp("crcStatus", 8'h00, crcStatus);
        cmp("status", 8'h00, protectStatus);
        finish_test();
    end
endmodule
